// *** hw/amp_output_config_regs.sv ***
// amplifier output configuration bank: loop bandwidth, gain, biquad write start,
// dac modulator settings and address pin direction, behind an apb slave
// assumes one 250 mhz pclk; adr_pin_in is asynchronous, adr_drive_value is on pclk
`timescale 1ns/1ns
`default_nettype none
module amp_output_config_regs (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [amp_cfg_pkg::ADDR_W-1:0] paddr,
   input  wire logic [amp_cfg_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                     pstrb,
   output logic                                pready,
   output logic      [amp_cfg_pkg::DATA_W-1:0] prdata,
   output logic                                pslverr,
   output logic      [1:0]                     loop_bandwidth_select,
   output logic      [7:0]                     loop_bandwidth_khz,
   output logic      [4:0]                     analog_gain_atten,
   output logic      [7:0]                     gain_atten_tenth_db,
   output logic                                filter_first_coef_flag,
   output logic                                first_coef_start,
   output logic                                dac_clk_6m144_sel,
   output logic                                dither_main_en,
   output logic                                dither_second_en,
   output logic      [2:0]                     dither_level,
   output logic      [4:0]                     dither_exponent,
   output logic                                dem_enable,
   input  wire logic                           adr_pin_in,
   input  wire logic                           adr_drive_value,
   output logic                                adr_pin_out,
   output logic                                adr_pin_oe,
   output logic                                adr_level
);
   import amp_cfg_pkg::*;

   reg_access_if bus ();

   logic [REG_W-1:0] bw_reg;
   logic [REG_W-1:0] gain_reg;
   logic [REG_W-1:0] bq_reg;
   logic [REG_W-1:0] dac_reg;
   logic [REG_W-1:0] dir_reg;
   logic             wr_bw;
   logic             wr_gain;
   logic             wr_bq;
   logic             wr_dac;
   logic             wr_dir;
   logic [REG_W-1:0] status_word;

   // pin synchroniser
   logic             adr_meta_d;
   logic             adr_meta_q;
   logic             adr_sync_d;
   logic             adr_sync_q;

   // registered decoded outputs
   logic [7:0]       bw_khz_d;
   logic [7:0]       bw_khz_q;
   logic [7:0]       atten_d;
   logic [7:0]       atten_q;
   logic             start_d;
   logic             start_q;
   logic             main_en_d;
   logic             main_en_q;
   logic             second_en_d;
   logic             second_en_q;
   logic [4:0]       exp_d;
   logic [4:0]       exp_q;
   logic             dem_en_d;
   logic             dem_en_q;
   logic             adr_out_d;
   logic             adr_out_q;

   apb_front u_front (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .pready  (pready),
      .prdata  (prdata),
      .pslverr (pslverr),
      .bus     (bus.front)
   );

   // write decode; the status word has no storage, so writes to it fall away
   always_comb
   begin
      wr_bw   = bus.wr & (bus.index == IDX_BANDWIDTH);
      wr_gain = bus.wr & (bus.index == IDX_GAIN);
      wr_bq   = bus.wr & (bus.index == IDX_BIQUAD);
      wr_dac  = bus.wr & (bus.index == IDX_DAC);
      wr_dir  = bus.wr & (bus.index == IDX_ADR_DIR);
   end

   // reserved bits are stored whole so they read back what was written
   cfg_reg #(.RESET(RST_BANDWIDTH)) u_bw (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_bw),
      .wdata   (bus.wdata),
      .q       (bw_reg)
   );

   cfg_reg #(.RESET(RST_GAIN)) u_gain (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_gain),
      .wdata   (bus.wdata),
      .q       (gain_reg)
   );

   cfg_reg #(.RESET(RST_BIQUAD)) u_bq (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_bq),
      .wdata   (bus.wdata),
      .q       (bq_reg)
   );

   cfg_reg #(.RESET(RST_DAC)) u_dac (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_dac),
      .wdata   (bus.wdata),
      .q       (dac_reg)
   );

   cfg_reg #(.RESET(RST_ADR_DIR)) u_dir (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_dir),
      .wdata   (bus.wdata),
      .q       (dir_reg)
   );

   // read side: pin level and direction as seen by this block
   always_comb
   begin
      status_word                 = 8'h00;
      status_word[STAT_LEVEL_BIT] = adr_sync_q;
      status_word[STAT_OE_BIT]    = dir_reg[ADR_OE_BIT];
   end

   always_comb
   begin
      bus.hit   = 1'b1;
      bus.rdata = 8'h00;
      case (bus.index)
         IDX_BANDWIDTH:  bus.rdata = bw_reg;
         IDX_GAIN:       bus.rdata = gain_reg;
         IDX_BIQUAD:     bus.rdata = bq_reg;
         IDX_DAC:        bus.rdata = dac_reg;
         IDX_ADR_DIR:    bus.rdata = dir_reg;
         IDX_PIN_STATUS: bus.rdata = status_word;
         default:        bus.hit   = 1'b0;
      endcase
   end

   // two-stage synchroniser; only the second stage is looked at
   always_comb
   begin
      adr_meta_d = adr_pin_in;
      adr_sync_d = adr_meta_q;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         adr_meta_q <= 1'b0;
         adr_sync_q <= 1'b0;
      end
      else
      begin
         adr_meta_q <= adr_meta_d;
         adr_sync_q <= adr_sync_d;
      end
   end

   // decoded settings, one edge behind the register that feeds them; the start strobe lands with the biquad write itself
   always_comb
   begin
      case (bw_reg[BW_MSB:BW_LSB])
         2'h0:    bw_khz_d = BW_KHZ_0;
         2'h1:    bw_khz_d = BW_KHZ_1;
         2'h2:    bw_khz_d = BW_KHZ_2;
         2'h3:    bw_khz_d = BW_KHZ_3;
         default: bw_khz_d = BW_KHZ_0;
      endcase
      // 31 steps of 5 tenths fit in eight bits
      atten_d = 8'({3'h0, gain_reg[GAIN_MSB:0]} * GAIN_STEP_TENTH_DB);
      // a set of the flag marks the next coefficient write as a section's first
      start_d     = wr_bq & bus.wdata[FIRST_COEF_BIT];
      main_en_d   = dac_reg[DITHER_EN_LSB];
      second_en_d = dac_reg[DITHER_EN_MSB];
      case (dac_reg[DITHER_LV_MSB:DITHER_LV_LSB])
         3'h0:    exp_d = DITHER_EXP_0;
         3'h1:    exp_d = DITHER_EXP_1;
         3'h2:    exp_d = DITHER_EXP_2;
         3'h3:    exp_d = DITHER_EXP_3;
         3'h4:    exp_d = DITHER_EXP_4;
         3'h5:    exp_d = DITHER_EXP_5;
         3'h6:    exp_d = DITHER_EXP_6;
         3'h7:    exp_d = DITHER_EXP_7;
         default: exp_d = DITHER_EXP_0;
      endcase
      // the two middle codes have no defined meaning; matching stays on for them
      dem_en_d  = (dac_reg[DEM_MSB:DEM_LSB] != DEM_OFF);
      adr_out_d = adr_drive_value;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bw_khz_q    <= BW_KHZ_0;
         atten_q     <= 8'h00;
         start_q     <= 1'b0;
         main_en_q   <= 1'b1;
         second_en_q <= 1'b1;
         exp_q       <= DITHER_EXP_6;
         dem_en_q    <= 1'b1;
         adr_out_q   <= 1'b0;
      end
      else
      begin
         bw_khz_q    <= bw_khz_d;
         atten_q     <= atten_d;
         start_q     <= start_d;
         main_en_q   <= main_en_d;
         second_en_q <= second_en_d;
         exp_q       <= exp_d;
         dem_en_q    <= dem_en_d;
         adr_out_q   <= adr_out_d;
      end
   end

   assign loop_bandwidth_select  = bw_reg[BW_MSB:BW_LSB];
   assign loop_bandwidth_khz     = bw_khz_q;
   assign analog_gain_atten      = gain_reg[GAIN_MSB:0];
   assign gain_atten_tenth_db    = atten_q;
   assign filter_first_coef_flag = bq_reg[FIRST_COEF_BIT];
   assign first_coef_start       = start_q;
   // 0 picks 6.144 mhz, 1 picks 3.072 mhz
   assign dac_clk_6m144_sel      = ~dac_reg[DAC_FREQ_BIT];
   assign dither_main_en         = main_en_q;
   assign dither_second_en       = second_en_q;
   assign dither_level           = dac_reg[DITHER_LV_MSB:DITHER_LV_LSB];
   assign dither_exponent        = exp_q;
   assign dem_enable             = dem_en_q;
   // pin stays an input out of reset, so nothing fights an external strap
   assign adr_pin_oe             = dir_reg[ADR_OE_BIT];
   assign adr_pin_out            = adr_out_q;
   assign adr_level              = adr_sync_q;
endmodule // amp_output_config_regs
`default_nettype wire

// *** hw/amp_cfg_pkg.sv ***
// constants, field layout and types for the amplifier output configuration bank
// assumes a 32-bit apb master and 8-bit registers placed one per aligned word
package amp_cfg_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_BANDWIDTH  = 8'h53;
   localparam logic [7:0] IDX_GAIN       = 8'h54;
   localparam logic [7:0] IDX_BIQUAD     = 8'h5c;
   localparam logic [7:0] IDX_DAC        = 8'h5d;
   localparam logic [7:0] IDX_ADR_DIR    = 8'h60;
   localparam logic [7:0] IDX_PIN_STATUS = 8'h70;

   // reset values
   localparam logic [7:0] RST_BANDWIDTH = 8'h00;
   localparam logic [7:0] RST_GAIN      = 8'h00;
   localparam logic [7:0] RST_BIQUAD    = 8'h00;
   localparam logic [7:0] RST_DAC       = 8'hf8;
   localparam logic [7:0] RST_ADR_DIR   = 8'h00;

   // field positions
   localparam int BW_LSB         = 5;
   localparam int BW_MSB         = 6;
   localparam int GAIN_MSB       = 4;
   localparam int FIRST_COEF_BIT = 0;
   localparam int DAC_FREQ_BIT   = 7;
   localparam int DITHER_EN_MSB  = 6;
   localparam int DITHER_EN_LSB  = 5;
   localparam int DITHER_LV_MSB  = 4;
   localparam int DITHER_LV_LSB  = 2;
   localparam int DEM_MSB        = 1;
   localparam int DEM_LSB        = 0;
   localparam int ADR_OE_BIT     = 0;
   localparam int STAT_LEVEL_BIT = 0;
   localparam int STAT_OE_BIT    = 1;

   // loop bandwidth in khz per code
   localparam logic [7:0] BW_KHZ_0 = 8'h50;
   localparam logic [7:0] BW_KHZ_1 = 8'h64;
   localparam logic [7:0] BW_KHZ_2 = 8'h78;
   localparam logic [7:0] BW_KHZ_3 = 8'haf;

   // attenuation per code step, tenths of a db
   localparam logic [7:0] GAIN_STEP_TENTH_DB = 8'h05;

   // element matching codes
   localparam logic [1:0] DEM_OFF = 2'h3;

   // dither level code to negative power of two
   localparam logic [4:0] DITHER_EXP_0 = 5'h0d;
   localparam logic [4:0] DITHER_EXP_1 = 5'h0e;
   localparam logic [4:0] DITHER_EXP_2 = 5'h0f;
   localparam logic [4:0] DITHER_EXP_3 = 5'h10;
   localparam logic [4:0] DITHER_EXP_4 = 5'h07;
   localparam logic [4:0] DITHER_EXP_5 = 5'h08;
   localparam logic [4:0] DITHER_EXP_6 = 5'h09;
   localparam logic [4:0] DITHER_EXP_7 = 5'h0a;

   typedef enum logic {PH_IDLE, PH_ACCESS} apb_phase_t;
endpackage

// *** hw/reg_access_if.sv ***
// internal register access carrier between the apb front end and the bank
// assumes both ends run on the same pclk
`timescale 1ns/1ns
`default_nettype none
interface reg_access_if;
   logic       wr;
   logic       rd;
   logic [7:0] index;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       hit;

   modport front (output wr, rd, index, wdata, input rdata, hit);
   modport core  (input wr, rd, index, wdata, output rdata, hit);
endinterface
`default_nettype wire

// *** hw/cfg_reg.sv ***
// one 8-bit read/write configuration register with a reset value
// assumes wr_en is a one-cycle strobe on pclk
`timescale 1ns/1ns
`default_nettype none
module cfg_reg #(
   parameter logic [7:0] RESET = 8'h00
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   output logic      [7:0] q
);
   logic [7:0] q_d;
   logic [7:0] q_q;

   always_comb
   begin
      q_d = q_q;
      if (wr_en)
      begin
         q_d = wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q_q <= RESET;
      end
      else
      begin
         q_q <= q_d;
      end
   end

   assign q = q_q;
endmodule // cfg_reg
`default_nettype wire

// *** hw/apb_front.sv ***
// apb slave front end: zero wait states, registered read data, error on a miss
// assumes an apb3/apb4 master on the same pclk
`timescale 1ns/1ns
`default_nettype none
module apb_front (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [amp_cfg_pkg::ADDR_W-1:0] paddr,
   input  wire logic [amp_cfg_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                     pstrb,
   output logic                                pready,
   output logic      [amp_cfg_pkg::DATA_W-1:0] prdata,
   output logic                                pslverr,
   reg_access_if.front                         bus
);
   import amp_cfg_pkg::*;

   apb_phase_t              phase_d;
   apb_phase_t              phase_q;
   logic [DATA_W-1:0]       prdata_d;
   logic [DATA_W-1:0]       prdata_q;
   logic                    err_d;
   logic                    err_q;
   logic                    setup;
   logic                    aligned;

   assign setup     = psel & ~penable;
   assign aligned   = (paddr[1:0] == 2'h0);
   assign bus.index = paddr[9:2];
   assign bus.wdata = pwdata[7:0];
   assign bus.rd    = setup & ~pwrite & aligned;
   // write lands at the edge closing the access phase; upper byte lanes carry nothing
   assign bus.wr    = (phase_q == PH_ACCESS) & psel & penable & pwrite & ~err_q & pstrb[0];

   always_comb
   begin
      phase_d  = phase_q;
      prdata_d = prdata_q;
      err_d    = err_q;
      case (phase_q)
         PH_IDLE:
         begin
            if (setup)
            begin
               phase_d  = PH_ACCESS;
               err_d    = ~aligned | ~bus.hit;
               prdata_d = {24'h00_0000, (bus.rd & bus.hit) ? bus.rdata : 8'h00};
            end
         end
         PH_ACCESS:
         begin
            phase_d = PH_IDLE;
         end
         default:
         begin
            phase_d = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_q  <= PH_IDLE;
         prdata_q <= 32'h0000_0000;
         err_q    <= 1'b0;
      end
      else
      begin
         phase_q  <= phase_d;
         prdata_q <= prdata_d;
         err_q    <= err_d;
      end
   end

   assign pready  = (phase_q == PH_ACCESS);
   assign pslverr = pready & err_q;
   assign prdata  = prdata_q;
endmodule // apb_front
`default_nettype wire

// *** tb/amp_cfg_assertions.sv ***
// concurrent checks on the amplifier configuration bank ports
// assumes zero-wait apb writes on pclk, derived outputs one edge behind
`timescale 1ns/1ns
`default_nettype none
module amp_cfg_checker
   import amp_cfg_pkg::*;
(
   input wire logic                           pclk,
   input wire logic                           presetn,
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic                           pwrite,
   input wire logic [amp_cfg_pkg::ADDR_W-1:0] paddr,
   input wire logic [amp_cfg_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0]                     pstrb,
   input wire logic                           pready,
   input wire logic [1:0]                     loop_bandwidth_select,
   input wire logic [7:0]                     loop_bandwidth_khz,
   input wire logic [4:0]                     analog_gain_atten,
   input wire logic [7:0]                     gain_atten_tenth_db,
   input wire logic                           dither_main_en,
   input wire logic                           dither_second_en,
   input wire logic                           adr_pin_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   function automatic logic [7:0] khz(input logic [1:0] c);
      return c == 2'h0 ? 8'h50 : c == 2'h1 ? 8'h64 : c == 2'h2 ? 8'h78 : 8'haf;
   endfunction

   // completed write with the low byte enabled
   sequence s_wr(logic [7:0] i);
      psel && penable && pwrite && pready && pstrb[0] && paddr == {i, 2'b00};
   endsequence

   property p_bw_wr;
      s_wr(IDX_BANDWIDTH) |=> loop_bandwidth_select == $past(pwdata[6:5]);
   endproperty
   a_bw_wr: assert property (p_bw_wr) else $error("bandwidth code not stored");
   property p_bw_khz;
      loop_bandwidth_khz == khz($past(loop_bandwidth_select));
   endproperty
   a_bw_khz: assert property (p_bw_khz) else $error("bandwidth khz wrong");
   property p_gain_wr;
      s_wr(IDX_GAIN) |=> analog_gain_atten == $past(pwdata[4:0]);
   endproperty
   a_gain_wr: assert property (p_gain_wr) else $error("gain code not stored");
   property p_gain_db;
      gain_atten_tenth_db == {3'h0, $past(analog_gain_atten)} * 8'h05;
   endproperty
   a_gain_db: assert property (p_gain_db) else $error("attenuation wrong");
   property p_dither;
      s_wr(IDX_DAC) |-> ##2 dither_main_en == $past(pwdata[5], 2) && dither_second_en == $past(pwdata[6], 2);
   endproperty
   a_dither: assert property (p_dither) else $error("dither stages wrong");
   property p_dir_wr;
      s_wr(IDX_ADR_DIR) |=> adr_pin_oe == $past(pwdata[0]);
   endproperty
   a_dir_wr: assert property (p_dir_wr) else $error("pin direction not stored");
   // direction only moves on a write
   property p_dir_hold;
      !(psel && penable && pwrite) |=> $stable(adr_pin_oe);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("pin direction moved");
endmodule // amp_cfg_checker
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the amplifier configuration bank
// assumes the checker module is compiled before this file
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import amp_cfg_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  pstrb = 4'hf;
   logic        adr_pin_in = 1'b0;
   logic        adr_drive_value = 1'b0;
   logic        pready, pslverr, filter_first_coef_flag, first_coef_start, dac_clk_6m144_sel;
   logic        dither_main_en, dither_second_en, dem_enable, adr_pin_out, adr_pin_oe, adr_level;
   logic [31:0] prdata;
   logic [1:0]  loop_bandwidth_select;
   logic [7:0]  loop_bandwidth_khz, gain_atten_tenth_db;
   logic [4:0]  analog_gain_atten, dither_exponent;
   logic [2:0]  dither_level;
   logic [31:0] rd;
   logic        err;
   int          fail_count = 0;
   int          total_checks = 0;

   always #2 pclk = ~pclk;

   amp_output_config_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .loop_bandwidth_select(loop_bandwidth_select), .loop_bandwidth_khz(loop_bandwidth_khz),
      .analog_gain_atten(analog_gain_atten), .gain_atten_tenth_db(gain_atten_tenth_db),
      .filter_first_coef_flag(filter_first_coef_flag), .first_coef_start(first_coef_start),
      .dac_clk_6m144_sel(dac_clk_6m144_sel), .dither_main_en(dither_main_en), .dither_second_en(dither_second_en),
      .dither_level(dither_level), .dither_exponent(dither_exponent), .dem_enable(dem_enable),
      .adr_pin_in(adr_pin_in), .adr_drive_value(adr_drive_value), .adr_pin_out(adr_pin_out),
      .adr_pin_oe(adr_pin_oe), .adr_level(adr_level));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // request held until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 8);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         fail_count++;
         end_sim;
      end
   endtask

   // derived outputs land one edge after the register
   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task automatic t_reset;
      logic [7:0] idx [5] = '{IDX_BANDWIDTH, IDX_GAIN, IDX_BIQUAD, IDX_DAC, IDX_ADR_DIR};
      logic [7:0] rst [5] = '{8'h00, 8'h00, 8'h00, 8'hf8, 8'h00};
      for (int k = 0; k < 5; k++)
      begin
         xfer(1'b0, idx[k], 32'h0000_0000);
         chk(rd, {24'h00_0000, rst[k]});
      end
      chk(loop_bandwidth_khz, 32'h0000_0050);
      chk(gain_atten_tenth_db, 32'h0000_0000);
      chk(dither_main_en, 32'h0000_0001);
      chk(dither_second_en, 32'h0000_0001);
      chk(adr_pin_oe, 32'h0000_0000);
      chk(first_coef_start, 32'h0000_0000);
      chk(filter_first_coef_flag, 32'h0000_0000);
      chk(dac_clk_6m144_sel, 32'h0000_0000);
      chk(dither_level, 32'h0000_0006);
      chk(dither_exponent, 32'(DITHER_EXP_6));
      chk(dem_enable, 32'h0000_0001);
      chk(adr_pin_out, 32'h0000_0000);
      chk(adr_level, 32'h0000_0000);
      $display("reset test done");
   endtask

   task automatic t_bw;
      logic [7:0] tbl [4] = '{8'h50, 8'h64, 8'h78, 8'haf};
      for (int c = 3; c >= 0; c--)
      begin
         xfer(1'b1, IDX_BANDWIDTH, c << 5);
         settle;
         chk(loop_bandwidth_select, c);
         chk(loop_bandwidth_khz, tbl[c]);
      end
      $display("bandwidth test done");
   endtask

   task automatic t_gain;
      for (int c = 31; c >= 0; c--)
      begin
         xfer(1'b1, IDX_GAIN, c);
         settle;
         chk(analog_gain_atten, c);
         chk(gain_atten_tenth_db, c * 5);
      end
      $display("gain test done");
   endtask

   task automatic t_dither;
      for (int c = 0; c < 4; c++)
      begin
         xfer(1'b1, IDX_DAC, 32'h0000_0098 | (c << 5));
         settle;
         chk(dither_main_en, c & 1);
         chk(dither_second_en, c >> 1);
      end
      // dac byte 0x03: fast modulator clock, both dither stages off, level 0, matching off
      xfer(1'b1, IDX_DAC, 32'h0000_0003);
      settle;
      chk(dither_main_en, 32'h0000_0000);
      chk(dither_second_en, 32'h0000_0000);
      chk(dac_clk_6m144_sel, 32'h0000_0001);
      chk(dither_level, 32'h0000_0000);
      chk(dither_exponent, 32'(DITHER_EXP_0));
      chk(dem_enable, 32'h0000_0000);
      xfer(1'b1, IDX_DAC, 32'h0000_009d);
      settle;
      chk(dac_clk_6m144_sel, 32'h0000_0000);
      chk(dither_level, 32'h0000_0007);
      chk(dither_exponent, 32'(DITHER_EXP_7));
      chk(dem_enable, 32'h0000_0001);
      $display("dither test done");
   endtask

   task automatic t_dir;
      xfer(1'b1, IDX_ADR_DIR, 32'h0000_0001);
      settle;
      chk(adr_pin_oe, 32'h0000_0001);
      @(posedge pclk);
      adr_pin_in <= 1'b1;
      adr_drive_value <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      chk(adr_pin_out, 32'h0000_0001);
      chk(adr_level, 32'h0000_0001);
      xfer(1'b0, IDX_PIN_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      xfer(1'b1, IDX_ADR_DIR, 32'h0000_0000);
      settle;
      chk(adr_pin_oe, 32'h0000_0000);
      $display("direction test done");
   endtask

   // unmapped index refused, then the first-coefficient strobe
   task automatic t_misc;
      xfer(1'b0, 8'hff, 32'h0000_0000);
      chk(err, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      // low byte lane off: the write must fall away without an error
      pstrb <= 4'he;
      xfer(1'b1, IDX_GAIN, 32'h0000_001f);
      pstrb <= 4'hf;
      chk(err, 32'h0000_0000);
      xfer(1'b0, IDX_GAIN, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      xfer(1'b1, IDX_BIQUAD, 32'h0000_0001);
      #1;
      chk(first_coef_start, 32'h0000_0001);
      settle;
      chk(filter_first_coef_flag, 32'h0000_0001);
      chk(first_coef_start, 32'h0000_0000);
      $display("misc test done");
   endtask

   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_bw;
      t_gain;
      t_dither;
      t_dir;
      t_misc;
      end_sim;
   end
endmodule // tb_top

bind amp_output_config_regs amp_cfg_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .loop_bandwidth_select(loop_bandwidth_select), .loop_bandwidth_khz(loop_bandwidth_khz),
   .analog_gain_atten(analog_gain_atten), .gain_atten_tenth_db(gain_atten_tenth_db),
   .dither_main_en(dither_main_en), .dither_second_en(dither_second_en), .adr_pin_oe(adr_pin_oe));
`default_nettype wire
